// *** hdl/apio_defines.svh ***
`ifndef APIO_DEFINES_SVH
`define APIO_DEFINES_SVH

// Register byte addresses on the bus.
`define APIO_ADDR_DATA 32'h5300_0000
`define APIO_ADDR_DIR 32'h5300_0004

// Register widths and the widened pin buses.
`define APIO_DATA_W 16
`define APIO_PIN_W 17
`define APIO_PAR_POS 16

// Direction encodings; only these two carry meaning.
`define APIO_DIR_IN 16'h0000
`define APIO_DIR_OUT 16'h0001

// Reset values of the stored state.
`define APIO_RST_DIR 16'h0000
`define APIO_RST_DATA 16'h0000
`define APIO_RST_PAR 1'b0
`define APIO_RST_CAPT 16'h0000
`define APIO_RST_FLAG 1'b0

// Transfer type bit that marks a non-idle, non-busy transfer.
`define APIO_TRANS_ACTIVE_BIT 1

`endif

// *** hdl/apio_pkg.sv ***
package apio_pkg;

   // Fault injection selection, driven from a pin.
   typedef enum logic [1:0] {
      APIO_INJ_NONE,
      APIO_INJ_IN_DATA,
      APIO_INJ_IN_PARITY,
      APIO_INJ_OUT_PARITY
   } apio_inject_e;

   // Which register a latched address phase selected.
   typedef enum logic [1:0] {
      APIO_SEL_NONE,
      APIO_SEL_DATA,
      APIO_SEL_DIR
   } apio_target_e;

   // State of the bus front end.
   typedef struct packed {
      logic pending_write;
      apio_target_e target;
      logic ready;
   } apio_front_s;

   // State of the port core.
   typedef struct packed {
      logic [15:0] dir;
      logic [15:0] out_data;
      logic out_parity;
      logic [15:0] captured;
      logic fault_flag;
   } apio_core_s;

endpackage

// *** hdl/apio_wr_if.sv ***
`timescale 1ns/1ps
// Write strobes passed from the bus front end to the register core.
interface apio_wr_if;
   logic wr_data;
   logic wr_dir;
   logic [15:0] wdata;
   modport front (output wr_data, output wr_dir, output wdata);
   modport core (input wr_data, input wr_dir, input wdata);
endinterface

// *** hdl/apio_ahb_front.sv ***
`timescale 1ns/1ps
`include "apio_defines.svh"
module apio_ahb_front (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic hready,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   apio_wr_if.front wr
);
   import apio_pkg::*;

   apio_front_s st;
   apio_front_s next_st;
   logic take;

   // An address phase is taken only when selected, the bus is ready and the
   // transfer is non-sequential or sequential.
   assign take = hsel & hready & htrans[`APIO_TRANS_ACTIVE_BIT];

   // Latch what the next data phase must do; ready never drops.
   always_comb begin
      next_st = st;
      next_st.ready = 1'b1;
      if (hready) begin
         next_st.pending_write = take & hwrite;
         if (!take) begin
            next_st.target = APIO_SEL_NONE;
         end else if (haddr == `APIO_ADDR_DATA) begin
            next_st.target = APIO_SEL_DATA;
         end else if (haddr == `APIO_ADDR_DIR) begin
            next_st.target = APIO_SEL_DIR;
         end else begin
            next_st.target = APIO_SEL_NONE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '{pending_write: 1'b0, target: APIO_SEL_NONE, ready: 1'b1};
      end else begin
         st <= next_st;
      end
   end

   // Write data belongs to the data phase, so strobes qualify it there.
   assign hreadyout = st.ready;
   assign wr.wr_data = st.pending_write & (st.target == APIO_SEL_DATA);
   assign wr.wr_dir = st.pending_write & (st.target == APIO_SEL_DIR);
   assign wr.wdata = hwdata[15:0];
endmodule

// *** hdl/apio_parity.sv ***
`timescale 1ns/1ps
`include "apio_defines.svh"
module apio_parity (
   input wire logic odd_select,
   input wire logic [15:0] gen_data,
   input wire logic [16:0] chk_word,
   output logic gen_bit,
   output logic chk_error
);
   // Even parity makes the total count of ones even, odd makes it odd.
   assign gen_bit = (^gen_data) ^ odd_select;
   // A checked word is bad when its total count of ones disagrees with the polarity.
   assign chk_error = (^chk_word) ^ odd_select;
endmodule

// *** hdl/ahb_parallel_io_with_parity.sv ***
// Contract
// - Behaves as a proper AHB-Lite slave.
// - Direction register is written at 0x5300_0004.
// - Zero means input, one means output.
// - Output mode data writes update the output pins.
// - Captured register loads every clock edge.
// - Captured register supplies low read data.
// - Parity stored with every output latch write.
// - Output pins widened to seventeen with parity.
// - Polarity pin high odd, low even.
// - Input pins seventeen bits, checked on capture.
// - Fault flag driven high on each mismatch; held low in output mode.
// - Parity errors never block captured data.
// - Fault injection pin corrupts data or parity.
`timescale 1ns/1ps
`include "apio_defines.svh"
module ahb_parallel_io_with_parity (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic hready,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic [31:0] hrdata,
   input wire logic [16:0] pins_in,
   output logic [16:0] pins_out,
   input wire logic parity_polarity_select,
   input wire apio_pkg::apio_inject_e fault_inject_select,
   output logic parity_fault_flag
);
   import apio_pkg::*;

   apio_core_s st;
   apio_core_s next_st;
   apio_wr_if wr ();
   logic output_mode;
   logic [16:0] checked_word;
   logic gen_bit;
   logic chk_error;
   logic size_unused;

   // Transfer size is accepted as given; only the low half-word is used.
   assign size_unused = ^hsize;

   // Address phase latch and data phase strobes, never inserting waits.
   apio_ahb_front u_front (
      .clk(clk),
      .rst(rst),
      .hsel(hsel),
      .hready(hready),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hreadyout(hreadyout),
      .wr(wr)
   );

   // Only the exact output encoding selects output mode; every other value,
   // including the meaningless ones, falls back to input for safety.
   assign output_mode = (st.dir == `APIO_DIR_OUT);

   // An injected input fault corrupts the word seen by the checker only, so
   // the input pins themselves and the stored capture stay honest.
   always_comb begin
      checked_word = pins_in;
      if (fault_inject_select == APIO_INJ_IN_DATA) begin
         checked_word[0] = ~pins_in[0];
      end else if (fault_inject_select == APIO_INJ_IN_PARITY) begin
         checked_word[`APIO_PAR_POS] = ~pins_in[`APIO_PAR_POS];
      end
   end

   // One parity unit serves both the output latch and the input check.
   apio_parity u_parity (
      .odd_select(parity_polarity_select),
      .gen_data(wr.wdata),
      .chk_word(checked_word),
      .gen_bit(gen_bit),
      .chk_error(chk_error)
   );

   // Next state of all registers.
   always_comb begin
      next_st = st;
      // The direction register is written whole, in any mode.
      if (wr.wr_dir) begin
         next_st.dir = wr.wdata;
      end
      // Data writes in input mode are dropped: the latch only moves when
      // the port is actually driving.
      if (wr.wr_data && output_mode) begin
         next_st.out_data = wr.wdata;
         next_st.out_parity = gen_bit;
         if (fault_inject_select == APIO_INJ_OUT_PARITY) begin
            next_st.out_parity = ~gen_bit;
         end
      end
      // Capture runs every edge; the source follows the current direction.
      if (output_mode) begin
         next_st.captured = st.out_data;
         next_st.fault_flag = 1'b0;
      end else begin
         next_st.captured = pins_in[15:0];
         next_st.fault_flag = chk_error;
      end
   end

   // Register everything; reset leaves the port in input mode.
   always_ff @(posedge clk) begin
      if (rst) begin
         st.dir <= `APIO_RST_DIR;
         st.out_data <= `APIO_RST_DATA;
         st.out_parity <= `APIO_RST_PAR;
         st.captured <= `APIO_RST_CAPT;
         st.fault_flag <= `APIO_RST_FLAG;
      end else begin
         st <= next_st;
      end
   end

   // All outputs come straight from registers.
   assign pins_out = {st.out_parity, st.out_data};
   assign hrdata = {16'h0000, st.captured};
   assign parity_fault_flag = st.fault_flag;
endmodule

// *** test/apio_asserts.sv ***
`timescale 1ns/1ps
module apio_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic hready,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] haddr,
   input wire logic [31:0] hwdata,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic [16:0] pins_in,
   input wire logic [16:0] pins_out,
   input wire logic parity_polarity_select,
   input wire apio_pkg::apio_inject_e fault_inject_select,
   input wire logic parity_fault_flag
);
   import apio_pkg::*;
   logic wd, wdir, outm, bad, act;
   logic [16:0] want;
   // Track write data phases and the mode they leave, as the master sees it.
   assign act = hsel && hready && htrans[1] && hwrite;
   always_ff @(posedge clk) begin
      if (rst) begin
         wd <= 1'b0;
         wdir <= 1'b0;
         outm <= 1'b0;
      end else begin
         wd <= act && haddr == 32'h5300_0000;
         wdir <= act && haddr == 32'h5300_0004;
         if (wdir) begin
            outm <= hwdata[15:0] == 16'h0001;
         end
      end
   end
   // Expected check result and latch word; injection flips exactly one bit.
   assign bad = ^pins_in ^ parity_polarity_select ^
      (fault_inject_select inside {APIO_INJ_IN_DATA, APIO_INJ_IN_PARITY});
   assign want = {^hwdata[15:0] ^ parity_polarity_select ^
      (fault_inject_select == APIO_INJ_OUT_PARITY), hwdata[15:0]};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_ready_high: assert property (hreadyout) else $error("wait state seen");
   a_rdata_upper: assert property (hrdata[31:16] == 16'h0)
      else $error("upper read data set");
   a_cap_in: assert property (!$past(rst) && !$past(outm) |->
      hrdata[15:0] == $past(pins_in[15:0])) else $error("input not captured");
   a_cap_out: assert property (!$past(rst) && $past(outm) |->
      hrdata[15:0] == $past(pins_out[15:0])) else $error("latch not captured");
   a_par_gen: assert property (wd && outm |=> pins_out == $past(want))
      else $error("latch or parity wrong");
   a_out_hold: assert property (!$past(rst) && !$past(wd && outm) |->
      $stable(pins_out)) else $error("latch changed");
   a_flag_chk: assert property (!$past(rst) && !$past(outm) |->
      parity_fault_flag == $past(bad)) else $error("parity flag wrong");
   a_flag_quiet: assert property ($past(outm) |-> !parity_fault_flag)
      else $error("flag in output mode");
   c_write: cover property (wd && outm);
   c_fault: cover property (parity_fault_flag);
   c_dir: cover property (wdir && hwdata[15:0] == 16'h0001);
endmodule

bind ahb_parallel_io_with_parity apio_chk chk_i (.clk, .rst, .hsel, .hready, .htrans,
   .hwrite, .haddr, .hwdata, .hreadyout, .hrdata, .pins_in, .pins_out,
   .parity_polarity_select, .fault_inject_select, .parity_fault_flag);

// *** test/apio_master.sv ***
`timescale 1ns/1ps
module apio_master (
   input wire logic clk,
   input wire logic go,
   input wire logic wr,
   input wire logic [31:0] addr,
   input wire logic [31:0] wd,
   input wire logic hreadyout,
   output logic hsel,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [31:0] haddr,
   output logic [31:0] hwdata
);
   logic dp = 1'b0;
   logic [31:0] wq = 32'h0;
   // Address phase while go is high; released lines show the inverse, never stale data.
   assign hsel = go;
   assign htrans = {go, 1'b0};
   assign hwrite = go & wr;
   assign haddr = go ? addr : ~addr;
   assign hwdata = dp ? wq : ~wq;
   // The data phase follows an accepted write address phase.
   always @(posedge clk) begin
      if (hreadyout) begin
         dp <= go && wr;
         wq <= wd;
      end
   end
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
   import apio_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic go = 1'b0;
   logic wr = 1'b0;
   logic sel = 1'b0;
   logic [31:0] addr = 32'h0;
   logic [31:0] wd = 32'h0;
   logic [16:0] pins_in = 17'h0;
   apio_inject_e inj = APIO_INJ_NONE;
   logic hsel, hwrite, rdy, flag;
   logic [1:0] htrans;
   logic [16:0] pins_out;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int failures = 0;
   int n_compared = 0;
   apio_master mst (.clk(clk), .go(go), .wr(wr), .addr(addr), .wd(wd), .hreadyout(rdy),
      .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .haddr(haddr), .hwdata(hwdata));
   ahb_parallel_io_with_parity dut (.clk(clk), .rst(rst), .hsel(hsel), .hready(rdy),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h1), .hwdata(hwdata),
      .hreadyout(rdy), .hrdata(hrdata), .pins_in(pins_in), .pins_out(pins_out),
      .parity_polarity_select(sel), .fault_inject_select(inj), .parity_fault_flag(flag));
   // Free-running bus clock.
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic par(input logic [15:0] v, input logic s);
      return ^v ^ s;
   endfunction
   // One transfer with an idle cycle after; read data is taken in the data phase.
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      go = 1'b1;
      wr = w;
      addr = a;
      wd = d;
      @(posedge clk);
      #2 go = 1'b0;
      rd = hrdata;
      @(posedge clk);
      #2;
   endtask
   task automatic t_reset;
      chk(pins_out, 32'h0);
      xfer(1'b0, 32'h5300_0004, 32'h0);
      chk(rd, 32'h0);
   endtask
   // Every polarity, good and bad parity, and every injection code in input mode.
   task automatic t_input;
      logic [15:0] v;
      for (int i = 0; i < 16; i++) begin
         v = 16'h3c5a ^ 16'(i * 32'h1021);
         sel = i[0];
         inj = apio_inject_e'(i[3:2]);
         pins_in = {par(v, i[0]) ^ i[1], v};
         @(posedge clk);
         #2 chk(hrdata, {16'h0, v});
         chk(flag, i[1] ^ (i[3:2] == 2'h1 || i[3:2] == 2'h2));
      end
   endtask
   // Refused writes, then output mode with both polarities and inverted parity.
   task automatic t_output;
      logic [15:0] v;
      xfer(1'b1, 32'h5300_0000, 32'h1234);
      xfer(1'b1, 32'h5300_0008, 32'h1);
      chk(pins_out, 32'h0);
      xfer(1'b1, 32'h5300_0004, 32'h1);
      for (int i = 0; i < 4; i++) begin
         v = 16'h8421 << i;
         sel = i[0];
         inj = i[1] ? APIO_INJ_OUT_PARITY : APIO_INJ_NONE;
         pins_in = {~par(16'h0f0f, i[0]), 16'h0f0f};
         xfer(1'b1, 32'h5300_0000, {16'hffff, v});
         chk(pins_out, {par(v, i[0]) ^ i[1], v});
         @(posedge clk);
         #2 chk(hrdata, {16'h0, v});
         chk(flag, 32'h0);
      end
      xfer(1'b1, 32'h5300_0004, 32'h0);
      // The edge that wrote the direction still captured the latch; input shows one edge later.
      @(posedge clk);
      #2 chk(hrdata, {16'h0, pins_in[15:0]});
      chk(flag, 32'h1);
   endtask
   // Reset in mid-run from output mode must clear the latch and return to input mode.
   task automatic t_midreset;
      xfer(1'b1, 32'h5300_0004, 32'h1);
      xfer(1'b1, 32'h5300_0000, 32'h00a5);
      chk(pins_out, {par(16'h00a5, sel), 16'h00a5});
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #2 rst = 1'b0;
      chk(pins_out, 32'h0);
      chk(hrdata, 32'h0);
      @(posedge clk);
      #2 chk(hrdata, {16'h0, pins_in[15:0]});
   endtask
   task automatic end_of_test;
      if (failures == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Hang guard, far beyond the seventy or so cycles the tests need.
   initial begin
      #50us;
      failures++;
      end_of_test();
   end
   initial begin
      repeat (20) @(posedge clk);
      #2 rst = 1'b0;
      t_reset();
      t_input();
      t_output();
      inj = APIO_INJ_NONE;
      t_midreset();
      end_of_test();
   end
endmodule
